// ### csg_pkg.sv
// Constants, register map and types shared by the clock source generator
package csg_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CSG_CLK_HZ = 20_000_000;
    localparam int unsigned CSG_LOW_OSC_HZ = 15_000;
    // Longest period of one low-speed tick, rounded down
    localparam int unsigned CSG_LOW_DIV_CYCLES = CSG_CLK_HZ / CSG_LOW_OSC_HZ;
    // Longest wait for the CPU source switch to settle while the sub clock runs
    localparam int unsigned CSG_STATUS_WAIT_MAX = 2000;

    // ==========================================================
    // Bus and register map (byte addresses)
    localparam int CSG_ADDR_W = 8;
    localparam logic [7:0] CSG_OSC_RUN_OFS = 8'h00;
    localparam logic [7:0] CSG_SYS_SEL_OFS = 8'h04;
    localparam logic [7:0] CSG_HS_DIV_OFS = 8'h08;
    localparam logic [7:0] CSG_SUB_SUPPLY_OFS = 8'h0C;
    localparam logic [7:0] CSG_OSC_STATUS_OFS = 8'h10;
    localparam logic [1:0] CSG_RESP_OKAY = 2'h0;
    localparam logic [1:0] CSG_RESP_SLVERR = 2'h2;

    // ==========================================================
    // Field positions
    localparam int CSG_MAIN_STOP_BIT = 7;
    localparam int CSG_SUB_STOP_BIT = 6;
    localparam int CSG_HS_STOP_BIT = 0;
    localparam int CSG_CPU_STATUS_BIT = 7;
    localparam int CSG_CPU_SEL_BIT = 6;
    localparam int CSG_MAIN_STATUS_BIT = 5;
    localparam int CSG_MAIN_SRC_BIT = 4;
    localparam int CSG_LOW_SUPPLY_BIT = 4;

    // ==========================================================
    // Values after reset
    localparam logic CSG_MAIN_STOP_RST = 1'h1;
    localparam logic CSG_SUB_STOP_RST = 1'h1;
    localparam logic CSG_HS_STOP_RST = 1'h0;
    localparam logic CSG_CPU_SEL_RST = 1'h0;
    localparam logic CSG_MAIN_SRC_RST = 1'h0;
    localparam logic CSG_LOW_SUPPLY_RST = 1'h0;
    localparam logic [2:0] CSG_HS_CODE_RST = 3'h0;

    // ==========================================================
    // High-speed oscillator frequency codes
    localparam logic [2:0] CSG_HS_24MHZ = 3'h0;
    localparam logic [2:0] CSG_HS_16MHZ = 3'h1;
    localparam logic [2:0] CSG_HS_12MHZ = 3'h2;
    localparam logic [2:0] CSG_HS_8MHZ = 3'h3;
    localparam logic [2:0] CSG_HS_4MHZ = 3'h4;
    localparam logic [2:0] CSG_HS_2MHZ = 3'h5;
    localparam logic [2:0] CSG_HS_1MHZ = 3'h6;

    // Low-speed consumers
    localparam int CSG_LP_WDT = 0;
    localparam int CSG_LP_RTC = 1;
    localparam int CSG_LP_ITMR = 2;
    localparam int CSG_LP_LCD = 3;
    localparam int CSG_LP_COUNT = 4;

    typedef enum logic [1:0] {
        CSG_SW_STEADY = 2'h0,
        CSG_SW_WAIT_OLD = 2'h1,
        CSG_SW_WAIT_NEW = 2'h3
    } csg_sw_state_type;

    // Scaled model: tick spacing in clock cycles, 48 over the frequency in MHz
    function automatic logic [5:0] csg_hs_period(input logic [2:0] code);
        case (code)
            CSG_HS_24MHZ: csg_hs_period = 6'h02;
            CSG_HS_16MHZ: csg_hs_period = 6'h03;
            CSG_HS_12MHZ: csg_hs_period = 6'h04;
            CSG_HS_8MHZ: csg_hs_period = 6'h06;
            CSG_HS_4MHZ: csg_hs_period = 6'h0C;
            CSG_HS_2MHZ: csg_hs_period = 6'h18;
            default: csg_hs_period = 6'h30;
        endcase
    endfunction

endpackage

// ### csg_tick_switch.sv
// Glitch-free switch between two clock-enable tick streams
`timescale 1ns/1ps
module csg_tick_switch (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Selection, 0 picks source a
    input wire logic i_sel,
    // Sources
    input wire logic i_tick_a,
    input wire logic i_tick_b,
    input wire logic i_run_a,
    input wire logic i_run_b,
    // Result
    output logic o_tick,
    output logic o_status
);
    import csg_pkg::*;

    csg_sw_state_type state_q, state_d;
    logic cur_q, cur_d;
    logic tick_q, tick_d;
    logic old_tick, new_tick, old_run;

    assign old_tick = cur_q ? i_tick_b : i_tick_a;
    assign new_tick = cur_q ? i_tick_a : i_tick_b;
    assign old_run = cur_q ? i_run_b : i_run_a;

    // ==========================================================
    // Switch sequencing
    // A running old source completes its period before the new source takes over,
    // so no shortened period reaches the consumer. A stopped target holds
    // the output silent until it runs.
    always_comb begin
        state_d = state_q;
        cur_d = cur_q;
        tick_d = 1'b0;
        case (state_q)
            CSG_SW_STEADY: begin
                tick_d = old_tick;
                if (i_sel != cur_q) begin
                    state_d = CSG_SW_WAIT_OLD;
                end
            end
            CSG_SW_WAIT_OLD: begin
                tick_d = old_tick;
                if (i_sel == cur_q) begin
                    state_d = CSG_SW_STEADY;
                end else if (old_tick || !old_run) begin
                    state_d = CSG_SW_WAIT_NEW;
                end
            end
            CSG_SW_WAIT_NEW: begin
                if (new_tick) begin
                    tick_d = 1'b1;
                    cur_d = ~cur_q;
                    state_d = CSG_SW_STEADY;
                end
            end
            default: begin
                state_d = CSG_SW_STEADY;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_q <= CSG_SW_STEADY;
            cur_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cur_q <= cur_d;
            tick_q <= tick_d;
        end
    end

    assign o_tick = tick_q;
    assign o_status = cur_q;

    sw_tick_source_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        o_tick |-> $past(i_tick_a || i_tick_b))
        else $error("switch output tick without a source tick");
    sw_gap_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (state_q == CSG_SW_WAIT_NEW && !new_tick) |=> !o_tick)
        else $error("tick passed while waiting for the new source");

endmodule

// ### csg_clock_source_generator.sv
// Clock source generator: oscillator control, source selection, AXI4-Lite registers
`timescale 1ns/1ps
module csg_clock_source_generator (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Option byte, captured during reset
    input wire logic [2:0] i_opt_hs_freq,
    input wire logic i_opt_watchdog_enable_option,
    input wire logic i_opt_watchdog_standby_run_option,
    // CPU standby state
    input wire logic i_stop_exec,
    input wire logic i_halt_exec,
    // Clock pins, sampled on i_mclk
    input wire logic i_ext_main_clock_pin,
    input wire logic i_ext_sub_clock_pin,
    // AXI4-Lite write
    input wire logic [csg_pkg::CSG_ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read
    input wire logic [csg_pkg::CSG_ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Clock enables
    output logic o_cpu_clk_en,
    output logic [csg_pkg::CSG_LP_COUNT-1:0] o_low_clk_en
);
    import csg_pkg::*;

    localparam int LOW_CNT_W = $clog2(CSG_LOW_DIV_CYCLES);
    localparam logic [LOW_CNT_W-1:0] LOW_LAST = LOW_CNT_W'(CSG_LOW_DIV_CYCLES - 1);

    // Register decode shared by the read and write paths
    function automatic logic csg_reg_hit(input logic [CSG_ADDR_W-1:0] addr);
        csg_reg_hit = (addr == CSG_OSC_RUN_OFS) || (addr == CSG_SYS_SEL_OFS) ||
            (addr == CSG_HS_DIV_OFS) || (addr == CSG_SUB_SUPPLY_OFS) ||
            (addr == CSG_OSC_STATUS_OFS);
    endfunction

    // ==========================================================
    // Register and bus state
    logic main_stop_q, main_stop_d, sub_stop_q, sub_stop_d, hs_stop_q, hs_stop_d;
    logic cpu_sel_q, cpu_sel_d, main_src_q, main_src_d, low_sup_q, low_sup_d;
    logic [2:0] div_code_q, div_code_d;
    logic div_ovr_q, div_ovr_d;
    logic [2:0] opt_code_q, opt_code_d;
    logic opt_wdt_q, opt_wdt_d, opt_sby_q, opt_sby_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [CSG_ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [7:0] wbyte_q, wbyte_d;
    logic wlane_q, wlane_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] rbyte;
    logic main_status, cpu_status;

    // ==========================================================
    // Oscillator state
    logic hs_run, main_run, sub_run, low_run;
    logic hs_tick, main_tick, sub_tick, low_tick, main_sel_tick;
    logic [2:0] eff_code;
    logic [5:0] hs_period;
    logic [5:0] hs_cnt_q, hs_cnt_d;
    logic [LOW_CNT_W-1:0] low_cnt_q, low_cnt_d;
    // Check helpers: cycles without a low tick, cycles of a pending CPU switch
    logic [LOW_CNT_W-1:0] low_gap_q, low_gap_d;
    logic [11:0] sw_wait_q, sw_wait_d;
    logic main_pin_q, sub_pin_q;
    logic [CSG_LP_COUNT-1:0] low_en_q;

    assign main_run = !(i_stop_exec || main_stop_q);
    assign hs_run = !(i_stop_exec || hs_stop_q);
    assign sub_run = !sub_stop_q;
    // Watchdog-only supply sleeps in standby unless standby run is chosen
    assign low_run = (opt_wdt_q || low_sup_q) &&
        !(opt_wdt_q && !low_sup_q && !opt_sby_q && (i_halt_exec || i_stop_exec));
    assign eff_code = div_ovr_q ? div_code_q : opt_code_q;
    assign hs_period = csg_hs_period(eff_code);
    assign hs_tick = hs_run && (hs_cnt_q == hs_period - 6'h01);
    assign low_tick = low_run && (low_cnt_q == LOW_LAST);
    // Same pin serves crystal and external clock; edge taken as a tick
    assign main_tick = main_run && i_ext_main_clock_pin && !main_pin_q;
    assign sub_tick = sub_run && i_ext_sub_clock_pin && !sub_pin_q;

    // ==========================================================
    // Oscillator counters
    always_comb begin
        hs_cnt_d = hs_cnt_q + 6'h01;
        if (!hs_run || hs_cnt_q >= hs_period - 6'h01) begin
            hs_cnt_d = 6'h00;
        end
        low_cnt_d = low_cnt_q + LOW_CNT_W'(1);
        if (!low_run || low_cnt_q == LOW_LAST) begin
            low_cnt_d = '0;
        end
        low_gap_d = '0;
        if (low_sup_q && !low_tick) begin
            low_gap_d = low_gap_q + LOW_CNT_W'(1);
        end
        sw_wait_d = 12'h000;
        if (cpu_status != cpu_sel_q && sub_run && sw_wait_q != 12'hFFF) begin
            sw_wait_d = sw_wait_q + 12'h001;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            hs_cnt_q <= 6'h00;
            low_cnt_q <= '0;
            low_gap_q <= '0;
            sw_wait_q <= 12'h000;
            main_pin_q <= 1'b0;
            sub_pin_q <= 1'b0;
        end else begin
            hs_cnt_q <= hs_cnt_d;
            low_cnt_q <= low_cnt_d;
            low_gap_q <= low_gap_d;
            sw_wait_q <= sw_wait_d;
            main_pin_q <= i_ext_main_clock_pin;
            sub_pin_q <= i_ext_sub_clock_pin;
        end
    end

    // Low-speed clock has no path into the CPU switches
    for (genvar g = 0; g < CSG_LP_COUNT; g++) begin : g_low_en
        always_ff @(posedge i_mclk) begin
            if (i_sys_rst) begin
                low_en_q[g] <= 1'b0;
            end else begin
                low_en_q[g] <= low_tick;
            end
        end
    end
    assign o_low_clk_en = low_en_q;

    // ==========================================================
    // Source switches: high-speed internal vs system, then main vs sub
    csg_tick_switch u_main_switch (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_sel(main_src_q),
        .i_tick_a(hs_tick),
        .i_tick_b(main_tick),
        .i_run_a(hs_run),
        .i_run_b(main_run),
        .o_tick(main_sel_tick),
        .o_status(main_status)
    );

    csg_tick_switch u_cpu_switch (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_sel(cpu_sel_q),
        .i_tick_a(main_sel_tick),
        .i_tick_b(sub_tick),
        // A stopped main source must not stall a switch away from it
        .i_run_a(main_src_q ? main_run : hs_run),
        .i_run_b(sub_run),
        .o_tick(o_cpu_clk_en),
        .o_status(cpu_status)
    );

    // ==========================================================
    // Register read data
    always_comb begin
        case (i_araddr)
            CSG_OSC_RUN_OFS: rbyte = {main_stop_q, sub_stop_q, 5'h00, hs_stop_q};
            CSG_SYS_SEL_OFS: rbyte = {cpu_status, cpu_sel_q, main_status, main_src_q, 4'h0};
            CSG_HS_DIV_OFS: rbyte = {5'h00, eff_code};
            CSG_SUB_SUPPLY_OFS: rbyte = {3'h0, low_sup_q, 4'h0};
            CSG_OSC_STATUS_OFS: rbyte = {4'h0, low_run, sub_run, main_run, hs_run};
            default: rbyte = 8'h00;
        endcase
    end

    // ==========================================================
    // Bus slave and register writes
    always_comb begin
        {main_stop_d, sub_stop_d, hs_stop_d} = {main_stop_q, sub_stop_q, hs_stop_q};
        {cpu_sel_d, main_src_d, low_sup_d} = {cpu_sel_q, main_src_q, low_sup_q};
        {div_code_d, div_ovr_d} = {div_code_q, div_ovr_q};
        {opt_code_d, opt_wdt_d, opt_sby_d} = {opt_code_q, opt_wdt_q, opt_sby_q};
        {aw_have_d, awaddr_d, w_have_d, wbyte_d, wlane_d} =
            {aw_have_q, awaddr_q, w_have_q, wbyte_q, wlane_q};
        {bvalid_d, bresp_d, rvalid_d, rresp_d, rdata_d} =
            {bvalid_q, bresp_q, rvalid_q, rresp_q, rdata_q};
        arready_d = arready_q;
        if (i_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = i_awaddr;
        end
        if (i_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wbyte_d = i_wdata[7:0];
            wlane_d = i_wstrb[0];
        end
        if (bvalid_q && i_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_have_q && w_have_q && !bvalid_q) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = csg_reg_hit(awaddr_q) ? CSG_RESP_OKAY : CSG_RESP_SLVERR;
            if (wlane_q) begin
                case (awaddr_q)
                    CSG_OSC_RUN_OFS: begin
                        main_stop_d = wbyte_q[CSG_MAIN_STOP_BIT];
                        sub_stop_d = wbyte_q[CSG_SUB_STOP_BIT];
                        hs_stop_d = wbyte_q[CSG_HS_STOP_BIT];
                    end
                    CSG_SYS_SEL_OFS: begin
                        cpu_sel_d = wbyte_q[CSG_CPU_SEL_BIT];
                        // Main source is frozen while the CPU select bit picks sub
                        if (!cpu_sel_q) begin
                            main_src_d = wbyte_q[CSG_MAIN_SRC_BIT];
                        end
                    end
                    CSG_HS_DIV_OFS: begin
                        div_code_d = wbyte_q[2:0];
                        div_ovr_d = 1'b1;
                    end
                    CSG_SUB_SUPPLY_OFS: begin
                        low_sup_d = wbyte_q[CSG_LOW_SUPPLY_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (rvalid_q && i_rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end else if (i_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rdata_d = {24'h000000, rbyte};
            rresp_d = csg_reg_hit(i_araddr) ? CSG_RESP_OKAY : CSG_RESP_SLVERR;
        end else if (!rvalid_q) begin
            // Opens the read channel after reset
            arready_d = 1'b1;
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            main_stop_q <= CSG_MAIN_STOP_RST;
            sub_stop_q <= CSG_SUB_STOP_RST;
            hs_stop_q <= CSG_HS_STOP_RST;
            cpu_sel_q <= CSG_CPU_SEL_RST;
            main_src_q <= CSG_MAIN_SRC_RST;
            low_sup_q <= CSG_LOW_SUPPLY_RST;
            div_code_q <= CSG_HS_CODE_RST;
            div_ovr_q <= 1'b0;
            // Option byte is held steady around reset and caught here
            opt_code_q <= i_opt_hs_freq;
            opt_wdt_q <= i_opt_watchdog_enable_option;
            opt_sby_q <= i_opt_watchdog_standby_run_option;
            {aw_have_q, w_have_q, bvalid_q, rvalid_q} <= 4'h0;
            {awready_q, wready_q, arready_q} <= 3'h0;
            awaddr_q <= '0;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
            bresp_q <= CSG_RESP_OKAY;
            rresp_q <= CSG_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            {main_stop_q, sub_stop_q, hs_stop_q} <= {main_stop_d, sub_stop_d, hs_stop_d};
            {cpu_sel_q, main_src_q, low_sup_q} <= {cpu_sel_d, main_src_d, low_sup_d};
            {div_code_q, div_ovr_q} <= {div_code_d, div_ovr_d};
            {opt_code_q, opt_wdt_q, opt_sby_q} <= {opt_code_d, opt_wdt_d, opt_sby_d};
            {aw_have_q, w_have_q, bvalid_q, rvalid_q} <= {aw_have_d, w_have_d, bvalid_d, rvalid_d};
            {awready_q, wready_q, arready_q} <= {awready_d, wready_d, 1'b1 & arready_d};
            awaddr_q <= awaddr_d;
            wbyte_q <= wbyte_d;
            wlane_q <= wlane_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign {o_awready, o_wready, o_arready} = {awready_q, wready_q, arready_q};
    assign {o_bvalid, o_bresp, o_rvalid, o_rresp} = {bvalid_q, bresp_q, rvalid_q, rresp_q};
    assign o_rdata = rdata_q;

    // ==========================================================
    // Checks
    main_osc_halt_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (i_stop_exec || main_stop_q) |-> !main_tick)
        else $error("main clock tick while main source is stopped");
    hs_freq_gap_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (hs_tick && $stable(eff_code) && hs_period > 6'h01) |=> !hs_tick)
        else $error("high-speed ticks closer than the selected period");
    reset_hs_source_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $past(i_sys_rst) |-> (!cpu_sel_q && !main_src_q && !hs_stop_q && !cpu_status))
        else $error("CPU not on high-speed internal source after reset");
    hs_osc_halt_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (i_stop_exec || hs_stop_q) |-> !hs_tick)
        else $error("high-speed tick while stopped");
    div_override_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (aw_have_q && w_have_q && !bvalid_q && wlane_q && awaddr_q == CSG_HS_DIV_OFS)
        |=> (eff_code == $past(wbyte_q[2:0])))
        else $error("divider write did not override the frequency");
    sub_osc_halt_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sub_stop_q |-> !sub_tick)
        else $error("sub clock tick while sub stop is set");
    cpu_no_low_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        o_cpu_clk_en |-> ($past(hs_tick || main_tick, 2) || $past(sub_tick)))
        else $error("CPU tick without a CPU-capable source");
    low_consumers_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        low_tick |=> (o_low_clk_en == {CSG_LP_COUNT{1'b1}}))
        else $error("low-speed tick not delivered to its consumers");
    low_run_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        low_gap_q <= LOW_LAST)
        else $error("low-speed oscillator idle while supply select is set");
    low_standby_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (opt_wdt_q && !low_sup_q && !opt_sby_q && (i_halt_exec || i_stop_exec))
        |-> (!low_tick && low_cnt_d == '0))
        else $error("watchdog-only low-speed clock ran in standby");
    cpu_status_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sw_wait_q < 12'(CSG_STATUS_WAIT_MAX))
        else $error("clock status did not follow the CPU source");

endmodule

// ### csg_clock_pins.sv
// Pin-side clock sources: external main clock and sub clock
`timescale 1ns/1ps
module csg_clock_pins #(
    parameter int MAIN_HALF = 2,
    parameter int SUB_HALF = 8
) (
    // Clock
    input wire logic i_mclk,
    // Pins
    output logic o_main_pin,
    output logic o_sub_pin
);
    int mcnt = 0;
    int scnt = 0;
    initial begin
        o_main_pin = 1'h0;
        o_sub_pin = 1'h0;
    end
    // ==========================================================
    // Free-running sources; sub is scaled, a true 32.768 kHz would stretch the run
    always @(posedge i_mclk) begin
        mcnt <= (mcnt + 1) % MAIN_HALF;
        scnt <= (scnt + 1) % SUB_HALF;
        if (mcnt == MAIN_HALF - 1) o_main_pin <= ~o_main_pin;
        if (scnt == SUB_HALF - 1) o_sub_pin <= ~o_sub_pin;
    end
endmodule

// ### csg_clock_source_generator_tb.sv
// Self-checking bench for the clock source generator
`timescale 1ns/1ps
module csg_clock_source_generator_tb;
    import csg_pkg::*;
    // ==========================================================
    // Signals
    logic i_mclk = 1'h0, i_sys_rst = 1'h1, i_stop_exec = 1'h0, i_halt_exec = 1'h0;
    logic [2:0] i_opt_hs_freq = 3'h2;
    logic i_opt_watchdog_enable_option = 1'h1, i_opt_watchdog_standby_run_option = 1'h0;
    logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_arvalid = 1'h0, i_bready = 1'h1, i_rready = 1'h1;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [3:0] i_wstrb = 4'hF, o_low_clk_en;
    logic [1:0] o_bresp, o_rresp;
    logic i_ext_main_clock_pin, i_ext_sub_clock_pin, o_awready, o_wready, o_bvalid;
    logic o_arready, o_rvalid, o_cpu_clk_en;
    int num_errors = 0, compares = 0;
    csg_clock_pins pins_u (.i_mclk, .o_main_pin(i_ext_main_clock_pin),
        .o_sub_pin(i_ext_sub_clock_pin));
    csg_clock_source_generator dut_u (.i_mclk, .i_sys_rst, .i_opt_hs_freq,
        .i_opt_watchdog_enable_option, .i_opt_watchdog_standby_run_option, .i_stop_exec,
        .i_halt_exec, .i_ext_main_clock_pin, .i_ext_sub_clock_pin, .i_awaddr, .i_awvalid,
        .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
        .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
        .o_cpu_clk_en, .o_low_clk_en);
    initial forever #25 i_mclk = ~i_mclk;
    // ==========================================================
    // Tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er = CSG_RESP_OKAY);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'h1;
        i_wvalid <= 1'h1;
        do begin
            @(posedge i_mclk);
            if (i_awvalid && o_awready) i_awvalid <= 1'h0;
            if (i_wvalid && o_wready) i_wvalid <= 1'h0;
        end while (o_bvalid !== 1'h1);
        compares++;
        if (o_bresp !== er) begin
            num_errors++;
            $display("mismatch bresp %h expected %h seen %h", a, er, o_bresp);
        end
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        i_araddr <= a;
        i_arvalid <= 1'h1;
        do begin
            @(posedge i_mclk);
            if (i_arvalid && o_arready) i_arvalid <= 1'h0;
        end while (o_rvalid !== 1'h1);
        compares++;
        if (o_rdata !== e || o_rresp !== er) begin
            num_errors++;
            $display("mismatch reg %h expected %h/%h seen %h/%h", a, e, er, o_rdata, o_rresp);
        end
    endtask
    // Counts cpu and low-speed pulses; a low pulse counts only when all four enables are set
    task automatic cnt(input int cyc, input int lc, input int hc, input int ll, input int hl);
        int c, l;
        c = 0;
        l = 0;
        repeat (cyc) begin
            @(posedge i_mclk);
            c += (o_cpu_clk_en === 1'h1);
            l += (o_low_clk_en === 4'hF);
        end
        compares++;
        if (c < lc || c > hc || l < ll || l > hl) begin
            num_errors++;
            $display("mismatch ticks expected %0d-%0d/%0d-%0d seen %0d/%0d", lc, hc, ll, hl, c, l);
        end
    endtask
    task automatic complete_run;
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        complete_run();
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (16) @(posedge i_mclk);
        i_sys_rst <= 1'h0;
        repeat (2) @(posedge i_mclk);
        chk(8'h00, 32'hC0, CSG_RESP_OKAY);
        chk(8'h04, 32'h00, CSG_RESP_OKAY);
        chk(8'h08, 32'h02, CSG_RESP_OKAY);
        cnt(400, 99, 101, 0, 1);
        wr(8'h08, 32'h04);
        chk(8'h08, 32'h04, CSG_RESP_OKAY);
        cnt(480, 39, 41, 0, 1);
        cnt(2700, 223, 227, 2, 3);
        i_halt_exec <= 1'h1;
        cnt(2700, 0, 9999, 0, 0);
        wr(8'h0C, 32'h10);
        cnt(2700, 0, 9999, 2, 3);
        i_halt_exec <= 1'h0;
        wr(8'h00, 32'h40);
        wr(8'h04, 32'h10);
        repeat (40) @(posedge i_mclk);
        chk(8'h04, 32'h30, CSG_RESP_OKAY);
        cnt(400, 99, 101, 0, 1);
        i_stop_exec <= 1'h1;
        repeat (8) @(posedge i_mclk);
        cnt(400, 0, 0, 0, 1);
        i_stop_exec <= 1'h0;
        wr(8'h00, 32'h00);
        wr(8'h04, 32'h50);
        repeat (100) @(posedge i_mclk);
        chk(8'h04, 32'hF0, CSG_RESP_OKAY);
        cnt(400, 24, 26, 0, 1);
        wr(8'h00, 32'h40);
        repeat (40) @(posedge i_mclk);
        cnt(400, 0, 0, 0, 1);
        wr(8'h20, 32'hFF, CSG_RESP_SLVERR);
        chk(8'h20, 32'h00, CSG_RESP_SLVERR);
        complete_run();
    end
endmodule
